/* mdc_cfg_ctrl.sv */
/*
  Configuration controller: shared settings from selector/paddle and remote port,
  mode indicators, configuring indicator, status and alarm.
  Assumes switches debounced and synchronous to clk; remote port is a plain
  address/data port with read data one cycle after the read strobe.
*/
// Contract
// - Jumper at local-only ignores all remote setting writes.
// - Jumper at alternate position accepts both local and remote changes.
// - Only selector positions 1 to 4 let the paddle act.
// - Position 1: any paddle action steps the display mode cyclically.
// - Exactly one mode indicator lit, matching the current mode.
// - Position 2: left decrements, right increments shift, Full Screen and Zoom only.
// - At minimum zoom, shift is held fixed and requests ignored.
// - Position 3 in Zoom: left raises zoom, right lowers it.
// - Position 4: left sets 7.5 percent, right 0 percent, 525-line only.
// - Held paddle in shift or zoom keeps stepping, more steps when held longer.
// - Shift range depends on input standard and zoom magnitude.
// - Configuring indicator on during init and configuration changes only.
// - Alarm raised on internal fault, configuration fault, or data error.
// - Input standard reported as 1080i, 1035i, 720p or none.
// - Field rate 50, 59.94, 60 Hz and output 525 or 625 reported.
// - Remote settings stay pending until an apply command.
// - Remote pedestal control only at 525 lines, withheld at 625.
// - Remote position on 256 scale maps to steps by max steps over 128.
// - One shift step moves picture about eight input pixels.
// - Zoom quantised to 35 values from letterbox to full screen.
// - After remote write, applied position returned on 256 scale, rounded.
// - Max shift 60 steps 1080i, 68 steps 1035i, 40 steps 720p.
// - 50 Hz input gives 625-line output; 59.94 or 60 Hz gives 525.
`timescale 1ns/1ps
`default_nettype none
module mdc_cfg_ctrl
  import mdc_pkg::*;
#(
  parameter int unsigned DELAY_CYC = MDC_REPEAT_DELAY_CYC,
  parameter int unsigned RATE_CYC  = MDC_REPEAT_RATE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       remote_lockout_jumper,
  input  wire logic [3:0] function_selector_switch,
  input  wire logic       paddle_step_switch_left,
  input  wire logic       paddle_step_switch_right,
  input  wire mdc_std_t   in_std,
  input  wire mdc_rate_t  in_rate,
  input  wire logic       internal_fault,
  input  wire logic       data_error,
  input  wire logic [2:0] rmt_addr,
  input  wire logic [7:0] rmt_wdata,
  input  wire logic       rmt_wr,
  input  wire logic       rmt_rd,
  output logic [7:0]      rmt_rdata,
  output mdc_cfg_t        cfg,
  output logic [3:0]      mode_led,
  output logic            configuring_indicator,
  output logic            alarm,
  output mdc_stat_t       stat
);
  mdc_cfg_t   cfg_r;
  mdc_cfg_t   pend_r;
  logic [7:0] pend_pos_r;
  logic       pend_valid_r;
  logic [7:0] rdata_r;
  logic [4:0] busy_r;
  logic       cfg_fault_r;
  logic       step_l;
  logic       step_r;
  logic       rep_en;
  logic [6:0] max_steps;
  logic [6:0] lim;
  logic       out_625;
  logic       remote_ok;
  logic       changed;

  function automatic logic [6:0] std_max(input mdc_std_t s);
    unique case (s)
      MDC_STD_1080I: std_max = MDC_SHIFT_1080;
      MDC_STD_1035I: std_max = MDC_SHIFT_1035;
      MDC_STD_720P:  std_max = MDC_SHIFT_720;
      MDC_STD_NONE:  std_max = 7'h00;
    endcase
  endfunction : std_max

  // Shift limit scales with zoom: zero at letterbox, full at maximum zoom
  function automatic logic [6:0] shift_lim(input logic [6:0] mx, input mdc_mode_t m,
                                           input logic [5:0] z);
    logic [12:0] p;
    p = 13'h0000;
    if (m == MDC_MODE_FULL) begin
      shift_lim = mx;
    end else if (m == MDC_MODE_ZOOM) begin
      p = 13'(mx) * 13'(z);
      shift_lim = 7'(p / 13'(MDC_ZOOM_MAX));
    end else begin
      shift_lim = 7'h00;
    end
  endfunction : shift_lim

  // Saturating signed add in the range -l..+l
  function automatic logic [7:0] sat_add(input logic [7:0] v, input logic signed [8:0] d,
                                         input logic [6:0] l);
    logic signed [9:0] s;
    s = 10'(signed'(v)) + 10'(d);
    if (s > signed'(10'(l))) begin
      sat_add = 8'(l);
    end else if (s < -signed'(10'(l))) begin
      sat_add = 8'(-signed'(10'(l)));
    end else begin
      sat_add = 8'(s);
    end
  endfunction : sat_add

  assign out_625   = (in_rate == MDC_RATE_50);
  assign max_steps = std_max(in_std);
  assign lim       = shift_lim(max_steps, cfg_r.mode, cfg_r.zoom);
  assign remote_ok = remote_lockout_jumper;
  assign rep_en    = (function_selector_switch == MDC_SEL_SHIFT)
                  || (function_selector_switch == MDC_SEL_ZOOM);

  mdc_paddle_rep #(
    .DELAY_CYC (DELAY_CYC),
    .RATE_CYC  (RATE_CYC)
  ) u_rep_left (
    .clk    (clk),
    .rst_b  (rst_b),
    .ce     (ce),
    .held   (paddle_step_switch_left && !paddle_step_switch_right),
    .rep_en (rep_en),
    .step   (step_l)
  );

  mdc_paddle_rep #(
    .DELAY_CYC (DELAY_CYC),
    .RATE_CYC  (RATE_CYC)
  ) u_rep_right (
    .clk    (clk),
    .rst_b  (rst_b),
    .ce     (ce),
    .held   (paddle_step_switch_right && !paddle_step_switch_left),
    .rep_en (rep_en),
    .step   (step_r)
  );

  // Pending remote selections; a write accepted only when lockout allows it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r       <= '{MDC_RST_MODE, MDC_RST_SHIFT, MDC_RST_ZOOM, MDC_RST_PED};
      pend_pos_r   <= 8'h00;
      pend_valid_r <= 1'b0;
    end else if (ce) begin
      if (rmt_wr && remote_ok) begin
        if (!pend_valid_r) begin
          pend_r     <= cfg_r;
          pend_pos_r <= 8'h80;
        end
        pend_valid_r <= 1'b1;
        unique case (rmt_addr)
          MDC_CMD_MODE:  pend_r.mode <= mdc_mode_t'(rmt_wdata[1:0]);
          MDC_CMD_PED:   if (!out_625) pend_r.ped_on <= rmt_wdata[0];
          MDC_CMD_HPOS:  pend_pos_r <= rmt_wdata;
          MDC_CMD_ZOOM:  pend_r.zoom <= (rmt_wdata[5:0] > MDC_ZOOM_MAX || |rmt_wdata[7:6])
                                        ? MDC_ZOOM_MAX : rmt_wdata[5:0];
          MDC_CMD_APPLY: pend_valid_r <= 1'b0;
          default:       ;
        endcase
      end
    end
  end

  // Remote slider position centred at 128: steps = (pos-128)*max/128, i.e. max*2/256 span
  function automatic logic [7:0] pos_to_shift(input logic [7:0] p, input logic [6:0] mx);
    logic signed [16:0] t;
    t = (17'(signed'({1'b0, p})) - 17'sd128) * 17'(mx);
    pos_to_shift = 8'(t / 17'sd128);
  endfunction : pos_to_shift

  // Shared settings: local paddle and remote apply both write here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= '{MDC_RST_MODE, MDC_RST_SHIFT, MDC_RST_ZOOM, MDC_RST_PED};
    end else if (ce) begin
      if (rmt_wr && remote_ok && rmt_addr == MDC_CMD_APPLY && pend_valid_r) begin
        cfg_r.mode   <= pend_r.mode;
        cfg_r.zoom   <= pend_r.zoom;
        cfg_r.ped_on <= pend_r.ped_on;
        // A zero limit (minimum zoom) parks the shift at centre in the same cycle
        cfg_r.shift <= sat_add(8'h00,
                       9'(signed'(pos_to_shift(pend_pos_r, std_max(in_std)))),
                       shift_lim(max_steps, pend_r.mode, pend_r.zoom));
      end else if (step_l || step_r) begin
        unique case (function_selector_switch)
          MDC_SEL_MODE: cfg_r.mode <= mdc_mode_t'(cfg_r.mode + 2'h1);
          MDC_SEL_SHIFT: begin
            if ((cfg_r.mode == MDC_MODE_FULL || cfg_r.mode == MDC_MODE_ZOOM) && lim != 7'h00) begin
              cfg_r.shift <= sat_add(cfg_r.shift, step_l ? -9'sd1 : 9'sd1, lim);
            end
          end
          MDC_SEL_ZOOM: begin
            if (cfg_r.mode == MDC_MODE_ZOOM) begin
              if (step_l && cfg_r.zoom != MDC_ZOOM_MAX) begin
                cfg_r.zoom <= cfg_r.zoom + 6'h01;
              end else if (step_r && cfg_r.zoom != 6'h00) begin
                cfg_r.zoom <= cfg_r.zoom - 6'h01;
              end
            end
          end
          MDC_SEL_PED: if (!out_625) cfg_r.ped_on <= step_l;
          default: ;
        endcase
      end else if (cfg_r.mode != MDC_MODE_FULL && cfg_r.mode != MDC_MODE_ZOOM) begin
        cfg_r.shift <= cfg_r.shift;
      end else if (sat_add(cfg_r.shift, 9'sd0, lim) != cfg_r.shift) begin
        // Zoom shrank beneath the current shift: pull it back inside the range
        cfg_r.shift <= sat_add(cfg_r.shift, 9'sd0, lim);
      end
    end
  end

  assign changed = ce && (
    (rmt_wr && remote_ok && rmt_addr == MDC_CMD_APPLY && pend_valid_r) ||
    ((step_l || step_r) && function_selector_switch >= MDC_SEL_MODE
     && function_selector_switch <= MDC_SEL_PED));

  // Busy counter covers initialisation and each configuration change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 5'(MDC_INIT_CYC);
    end else if (ce) begin
      if (changed) begin
        busy_r <= 5'(MDC_BUSY_CYC);
      end else if (busy_r != 5'h00) begin
        busy_r <= busy_r - 5'h01;
      end
    end
  end

  // Configuration fault: only one of standard and rate detected, or a 50 Hz input that is not 1080i
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_fault_r <= 1'b0;
    end else if (ce) begin
      cfg_fault_r <= (in_std == MDC_STD_NONE) != (in_rate == MDC_RATE_NONE)
                  || (in_std != MDC_STD_1080I && in_rate == MDC_RATE_50);
    end
  end

  // Remote read-back; position converted back to the 256 scale, rounded
  function automatic logic [7:0] shift_to_pos(input logic [7:0] s, input logic [6:0] mx);
    logic signed [16:0] t;
    logic signed [16:0] q;
    t = 17'sd0;
    q = 17'sd0;
    if (mx == 7'h00) begin
      shift_to_pos = 8'h80;
    end else begin
      // Signed division throughout; half a step added away from zero rounds
      t = 17'(signed'(s)) * 17'sd128;
      if (t < 17'sd0) begin
        t = t - signed'(17'(mx >> 1));
      end else begin
        t = t + signed'(17'(mx >> 1));
      end
      q = t / signed'(17'(mx));
      shift_to_pos = 8'(q + 17'sd128);
    end
  endfunction : shift_to_pos

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      if (rmt_rd) begin
        unique case (rmt_addr)
          MDC_CMD_MODE: rdata_r <= {6'h00, cfg_r.mode};
          MDC_CMD_PED:  rdata_r <= {7'h00, cfg_r.ped_on & !out_625};
          MDC_CMD_HPOS: rdata_r <= shift_to_pos(cfg_r.shift, max_steps);
          MDC_CMD_ZOOM: rdata_r <= {2'h0, cfg_r.zoom};
          MDC_CMD_STAT: rdata_r <= {2'h0, pend_valid_r, out_625, in_rate, in_std};
          default:      rdata_r <= 8'h00;
        endcase
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign rmt_rdata             = rdata_r;
  assign cfg                   = cfg_r;
  assign mode_led              = 4'h1 << cfg_r.mode;
  assign configuring_indicator = (busy_r != 5'h00);
  assign alarm                 = internal_fault || data_error || cfg_fault_r;
  assign stat                  = '{in_std, in_rate, out_625};
endmodule : mdc_cfg_ctrl
`default_nettype wire

/* mdc_cfg_ctrl_chk.sv */
/* Port-level checker for the configuration controller.
   Assumes it is bound to mdc_cfg_ctrl and sees one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module mdc_cfg_ctrl_chk
  import mdc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       remote_lockout_jumper,
  input wire logic [3:0] function_selector_switch,
  input wire mdc_std_t   in_std,
  input wire mdc_rate_t  in_rate,
  input wire logic       internal_fault,
  input wire logic       data_error,
  input wire logic [2:0] rmt_addr,
  input wire logic       rmt_rd,
  input wire logic [7:0] rmt_rdata,
  input wire mdc_cfg_t   cfg,
  input wire logic [3:0] mode_led,
  input wire logic       configuring_indicator,
  input wire logic       alarm,
  input wire mdc_stat_t  stat
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic idle_sel = (function_selector_switch == 4'h0) || (function_selector_switch > 4'h4);

  property p_led; mode_led == (4'h1 << cfg.mode); endproperty
  a_led: assert property (p_led) else $error("mode indicator mismatch");
  // Three cycles so a step launched before the selector moved has landed
  property p_locked; (!remote_lockout_jumper && idle_sel) [*3] |=> $stable(cfg); endproperty
  a_locked: assert property (p_locked) else $error("settings moved while locked");
  property p_init; $rose(rst_b) |-> configuring_indicator [*8]; endproperty
  a_init: assert property (p_init) else $error("indicator off during init");
  property p_alarm; internal_fault || data_error |-> alarm; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing");
  property p_cfgfault; (in_rate == MDC_RATE_50 && in_std == MDC_STD_720P) [*3] |-> alarm; endproperty
  a_cfgfault: assert property (p_cfgfault) else $error("config fault alarm missing");
  property p_std; stat.std == in_std && stat.rate == in_rate; endproperty
  a_std: assert property (p_std) else $error("status mismatch");
  property p_625; stat.out_625 == (in_rate == MDC_RATE_50); endproperty
  a_625: assert property (p_625) else $error("output standard mismatch");
  property p_pedrd; rmt_rd && rmt_addr == MDC_CMD_PED && in_rate == MDC_RATE_50 |=> rmt_rdata == 8'h00;
  endproperty
  a_pedrd: assert property (p_pedrd) else $error("pedestal exposed at 625");
  property p_zoom; cfg.zoom <= MDC_ZOOM_MAX; endproperty
  a_zoom: assert property (p_zoom) else $error("zoom out of range");
  property p_shift; $signed(cfg.shift) >= -68 && $signed(cfg.shift) <= 68; endproperty
  a_shift: assert property (p_shift) else $error("shift out of range");
  property p_frozen; cfg.mode == MDC_MODE_ZOOM && cfg.zoom == 6'h00 && $stable(cfg.mode)
    && $stable(cfg.zoom)
    |=> $stable(cfg.shift) || cfg.zoom != 6'h00 || cfg.mode != MDC_MODE_ZOOM; endproperty
  a_frozen: assert property (p_frozen) else $error("shift moved at minimum zoom");
endmodule : mdc_cfg_ctrl_chk

bind mdc_cfg_ctrl mdc_cfg_ctrl_chk u_mdc_cfg_ctrl_chk (
  .clk(clk), .rst_b(rst_b), .remote_lockout_jumper(remote_lockout_jumper),
  .function_selector_switch(function_selector_switch), .in_std(in_std), .in_rate(in_rate),
  .internal_fault(internal_fault), .data_error(data_error), .rmt_addr(rmt_addr),
  .rmt_rd(rmt_rd), .rmt_rdata(rmt_rdata), .cfg(cfg), .mode_led(mode_led),
  .configuring_indicator(configuring_indicator), .alarm(alarm), .stat(stat));
`default_nettype wire

/* mdc_cfg_ctrl_tb.sv */
/* Testbench: drives switches, remote port and status inputs, compares with a model.
   Assumes repeat timing shortened to 20/5 cycles. */
`timescale 1ns/1ps
`default_nettype none
module mdc_cfg_ctrl_tb
  import mdc_pkg::*;
;
  logic            clk, rst_b, ce, remote_lockout_jumper, internal_fault, data_error;
  mdc_std_t        in_std;
  mdc_rate_t       in_rate;
  wire logic [3:0] function_selector_switch;
  wire logic       paddle_step_switch_left, paddle_step_switch_right, rmt_wr, rmt_rd;
  wire logic [2:0] rmt_addr;
  wire logic [7:0] rmt_wdata;
  logic [7:0]      rmt_rdata, rd_v;
  mdc_cfg_t        cfg;
  logic [3:0]      mode_led;
  logic            configuring_indicator, alarm, flt;
  mdc_stat_t       stat;
  int              miscompares, comparisons, cycles, n, p, m_mode, m_shift, m_zoom, m_ped;

  mdc_cfg_ctrl #(.DELAY_CYC(20), .RATE_CYC(5)) u_mdc_cfg_ctrl (
    .clk(clk), .rst_b(rst_b), .ce(ce), .remote_lockout_jumper(remote_lockout_jumper),
    .function_selector_switch(function_selector_switch),
    .paddle_step_switch_left(paddle_step_switch_left),
    .paddle_step_switch_right(paddle_step_switch_right), .in_std(in_std), .in_rate(in_rate),
    .internal_fault(internal_fault), .data_error(data_error), .rmt_addr(rmt_addr),
    .rmt_wdata(rmt_wdata), .rmt_wr(rmt_wr), .rmt_rd(rmt_rd), .rmt_rdata(rmt_rdata), .cfg(cfg),
    .mode_led(mode_led), .configuring_indicator(configuring_indicator), .alarm(alarm),
    .stat(stat));

  mdc_partner u_mdc_partner (
    .clk(clk), .rmt_rdata(rmt_rdata), .rmt_addr(rmt_addr), .rmt_wdata(rmt_wdata),
    .rmt_wr(rmt_wr), .rmt_rd(rmt_rd), .sel(function_selector_switch),
    .pad_l(paddle_step_switch_left), .pad_r(paddle_step_switch_right));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cmp_cfg;
    chk(cfg.mode, m_mode);
    chk(mode_led, 1 << m_mode);
    chk({{24{cfg.shift[7]}}, cfg.shift}, m_shift);
    chk(cfg.zoom, m_zoom);
    chk(cfg.ped_on, m_ped);
  endtask : cmp_cfg

  task automatic apply;
    u_mdc_partner.wr(MDC_CMD_APPLY, 8'h00);
    repeat (3) @(posedge clk);
  endtask : apply

  task automatic end_of_test;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial begin
    {clk, rst_b, ce, remote_lockout_jumper, internal_fault, data_error} = 6'h08;
    {in_std, in_rate} = {MDC_STD_1080I, MDC_RATE_60};
    {m_mode, m_shift, m_zoom, m_ped} = {32'h0, 32'h0, 32'h0, 32'h1};
    void'($urandom(32'h6d485eaa));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    cmp_cfg();
    for (n = 0; n < 100 && configuring_indicator !== 1'b0; n++) @(posedge clk);
    chk(configuring_indicator, 1'b0);
    for (n = 0; n < 16; n++) if (n == 0 || n > 4) begin
      u_mdc_partner.press(n[3:0], 1'($urandom % 2), 30);
      cmp_cfg();
    end
    // Six presses wrap the mode once and leave Full Screen
    for (n = 0; n < 6; n++) begin
      u_mdc_partner.press(MDC_SEL_MODE, 1'($urandom % 2), 30);
      m_mode = (m_mode + 1) % 4;
      cmp_cfg();
    end
    u_mdc_partner.press(MDC_SEL_SHIFT, 1'b1, 1);
    m_shift = -1;
    cmp_cfg();
    u_mdc_partner.press(MDC_SEL_SHIFT, 1'b0, 1);
    u_mdc_partner.press(MDC_SEL_SHIFT, 1'b0, 1);
    m_shift = 1;
    cmp_cfg();
    u_mdc_partner.press(MDC_SEL_SHIFT, 1'b0, 500);
    m_shift = 60;
    cmp_cfg();
    u_mdc_partner.wr(MDC_CMD_HPOS, 8'h80);
    apply();
    cmp_cfg();
    remote_lockout_jumper <= 1'b1;
    u_mdc_partner.wr(MDC_CMD_HPOS, 8'hC0);
    cmp_cfg();
    apply();
    m_shift = 30;
    cmp_cfg();
    u_mdc_partner.rd(MDC_CMD_HPOS, rd_v);
    chk(rd_v, 8'hC0);
    repeat (3) begin
      p = $urandom % 256;
      u_mdc_partner.wr(MDC_CMD_HPOS, p[7:0]);
      apply();
      m_shift = (p - 128) * 60 / 128;
      cmp_cfg();
    end
    u_mdc_partner.wr(MDC_CMD_HPOS, 8'h80);
    u_mdc_partner.wr(MDC_CMD_MODE, 8'h03);
    apply();
    {m_shift, m_mode} = {32'h0, 32'h3};
    cmp_cfg();
    u_mdc_partner.press(MDC_SEL_ZOOM, 1'b0, 1);
    u_mdc_partner.press(MDC_SEL_SHIFT, 1'b0, 1);
    cmp_cfg();
    u_mdc_partner.press(MDC_SEL_ZOOM, 1'b1, 500);
    u_mdc_partner.press(MDC_SEL_ZOOM, 1'b0, 1);
    m_zoom = 33;
    cmp_cfg();
    u_mdc_partner.wr(MDC_CMD_ZOOM, 8'h32);
    apply();
    m_zoom = 34;
    cmp_cfg();
    u_mdc_partner.press(MDC_SEL_PED, 1'b0, 1);
    m_ped = 0;
    cmp_cfg();
    u_mdc_partner.press(MDC_SEL_PED, 1'b1, 1);
    m_ped = 1;
    cmp_cfg();
    in_rate <= MDC_RATE_50;
    u_mdc_partner.press(MDC_SEL_PED, 1'b0, 1);
    u_mdc_partner.wr(MDC_CMD_PED, 8'h00);
    apply();
    cmp_cfg();
    u_mdc_partner.rd(MDC_CMD_PED, rd_v);
    chk(rd_v, 8'h00);
    in_rate <= MDC_RATE_60;
    u_mdc_partner.wr(MDC_CMD_ZOOM, 8'h11);
    apply();
    u_mdc_partner.press(MDC_SEL_SHIFT, 1'b0, 500);
    {m_zoom, m_shift} = {32'd17, 32'd30};
    cmp_cfg();
    ce <= 1'b0;
    u_mdc_partner.press(MDC_SEL_MODE, 1'b1, 4);
    ce <= 1'b1;
    cmp_cfg();
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      in_std <= mdc_std_t'(n[3:2]);
      in_rate <= mdc_rate_t'(n[1:0]);
      internal_fault <= 1'($urandom % 2);
      data_error <= ($urandom % 4 == 0);
      repeat (4) @(posedge clk);
      flt = ((n[3:2] == 0) != (n[1:0] == 0)) || (n[1:0] == 1 && n[3:2] != 1);
      chk(stat, {n[3:0], n[1:0] == 2'h1});
      chk(alarm, flt | internal_fault | data_error);
    end
    end_of_test();
  end
endmodule : mdc_cfg_ctrl_tb
`default_nettype wire

/* mdc_paddle_rep.sv */
/*
  Paddle auto-repeat: one step pulse on press, then repeated pulses while held.
  Assumes paddle inputs are debounced and synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mdc_paddle_rep
  import mdc_pkg::*;
#(
  parameter int unsigned DELAY_CYC = MDC_REPEAT_DELAY_CYC,
  parameter int unsigned RATE_CYC  = MDC_REPEAT_RATE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic held,
  input  wire logic rep_en,
  output logic      step
);
  logic [23:0] cnt_r;
  logic        held_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      held_r <= 1'b0;
    end else if (ce) begin
      held_r <= held;
    end
  end

  // Counter restarts the repeat interval after each pulse, so steps grow with hold time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 24'h000000;
    end else if (ce) begin
      if (!held || !held_r) begin
        cnt_r <= 24'(DELAY_CYC);
      end else if (cnt_r == 24'h000000) begin
        cnt_r <= 24'(RATE_CYC);
      end else begin
        cnt_r <= cnt_r - 24'h000001;
      end
    end
  end

  assign step = ce && held && (!held_r || (rep_en && cnt_r == 24'h000000));
endmodule : mdc_paddle_rep
`default_nettype wire

/* mdc_partner.sv */
/* Far-side model: front-panel switches and the remote network controller.
   Assumes a free-running clk; all requests change right after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module mdc_partner (
  input  wire logic       clk,
  input  wire logic [7:0] rmt_rdata,
  output logic [2:0]      rmt_addr,
  output logic [7:0]      rmt_wdata,
  output logic            rmt_wr,
  output logic            rmt_rd,
  output logic [3:0]      sel,
  output logic            pad_l,
  output logic            pad_r
);
  initial {rmt_addr, rmt_wdata, rmt_wr, rmt_rd, sel, pad_l, pad_r} = '0;

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {rmt_wr, rmt_addr, rmt_wdata} <= {1'b1, a, d};
    @(posedge clk);
    // Idle data no longer shows the last byte
    {rmt_wr, rmt_wdata} <= {1'b0, ~d};
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    {rmt_rd, rmt_addr} <= {1'b1, a};
    @(posedge clk);
    rmt_rd <= 1'b0;
    // Read data stand only in this cycle; take them mid-cycle, clear of the edges
    @(negedge clk);
    d = rmt_rdata;
  endtask : rd

  // Selector settles one cycle before the paddle moves
  task automatic press(input logic [3:0] s, input logic left, input int n);
    @(posedge clk);
    sel <= s;
    @(posedge clk);
    {pad_l, pad_r} <= {left, !left};
    repeat (n) @(posedge clk);
    {pad_l, pad_r} <= 2'h0;
    repeat (8) @(posedge clk);
  endtask : press
endmodule : mdc_partner
`default_nettype wire

/* mdc_pkg.sv */
/*
  Package for the monitor downconverter configuration controller: modes, standards,
  remote command codes, limits and timing constants.
  Assumes a 10 MHz system clock.
*/
package mdc_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // Display modes; indicator bits follow the same order
  typedef enum logic [1:0] {
    MDC_MODE_LBOX  = 2'h0,
    MDC_MODE_AMOR  = 2'h1,
    MDC_MODE_FULL  = 2'h2,
    MDC_MODE_ZOOM  = 2'h3
  } mdc_mode_t;

  typedef enum logic [1:0] {
    MDC_STD_NONE  = 2'h0,
    MDC_STD_1080I = 2'h1,
    MDC_STD_1035I = 2'h2,
    MDC_STD_720P  = 2'h3
  } mdc_std_t;

  typedef enum logic [1:0] {
    MDC_RATE_NONE = 2'h0,
    MDC_RATE_50   = 2'h1,
    MDC_RATE_5994 = 2'h2,
    MDC_RATE_60   = 2'h3
  } mdc_rate_t;

  // Remote command port: write selects a field, apply commits pending fields
  localparam logic [2:0] MDC_CMD_MODE  = 3'h0;
  localparam logic [2:0] MDC_CMD_PED   = 3'h1;
  localparam logic [2:0] MDC_CMD_HPOS  = 3'h2;
  localparam logic [2:0] MDC_CMD_ZOOM  = 3'h3;
  localparam logic [2:0] MDC_CMD_APPLY = 3'h4;
  localparam logic [2:0] MDC_CMD_STAT  = 3'h5;

  localparam logic [3:0] MDC_SEL_MODE  = 4'h1;
  localparam logic [3:0] MDC_SEL_SHIFT = 4'h2;
  localparam logic [3:0] MDC_SEL_ZOOM  = 4'h3;
  localparam logic [3:0] MDC_SEL_PED   = 4'h4;

  localparam logic [6:0] MDC_SHIFT_1080 = 7'h3C;
  localparam logic [6:0] MDC_SHIFT_1035 = 7'h44;
  localparam logic [6:0] MDC_SHIFT_720  = 7'h28;
  localparam int unsigned MDC_PIX_PER_STEP = 8;
  localparam logic [5:0] MDC_ZOOM_MAX   = 6'h22;
  localparam int unsigned MDC_REMOTE_STEPS = 256;

  // Reset values
  localparam mdc_mode_t  MDC_RST_MODE  = MDC_MODE_LBOX;
  localparam logic [7:0] MDC_RST_SHIFT = 8'h00;
  localparam logic [5:0] MDC_RST_ZOOM  = 6'h00;
  localparam logic       MDC_RST_PED   = 1'b1;

  // Paddle auto-repeat timing; init and busy lengths of the configuring indicator
  localparam int unsigned MDC_REPEAT_DELAY_MS = 500;
  localparam int unsigned MDC_REPEAT_RATE_MS  = 100;
  localparam int unsigned MDC_REPEAT_DELAY_CYC = CLK_HZ / 1000 * MDC_REPEAT_DELAY_MS;
  localparam int unsigned MDC_REPEAT_RATE_CYC  = CLK_HZ / 1000 * MDC_REPEAT_RATE_MS;
  localparam int unsigned MDC_INIT_CYC = 16;
  localparam int unsigned MDC_BUSY_CYC = 4;

  typedef struct packed {
    mdc_mode_t  mode;
    logic [7:0] shift;   // signed steps, two's complement
    logic [5:0] zoom;
    logic       ped_on;
  } mdc_cfg_t;

  typedef struct packed {
    mdc_std_t  std;
    mdc_rate_t rate;
    logic      out_625;
  } mdc_stat_t;

endpackage : mdc_pkg
